// file: hw/addr_modify_consts.svh
// Constants for the address-modify and store-address execution block.
`ifndef ADDR_MODIFY_CONSTS_SVH
`define ADDR_MODIFY_CONSTS_SVH

`define CLK_PERIOD_NS         10
`define INDEX_LOAD_TIME_US    6
`define STORE_ADDR_TIME_US    18
`define INDEX_LOAD_CYCLES     ((`INDEX_LOAD_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_ADDR_CYCLES     ((`STORE_ADDR_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W               12

`define OPC_INDEX_LOAD_FROM_RIGHT_ACC 9'h1f4
`define OPC_STORE_ADDRESS_HALF        9'h0e0

`define SEL_IDX1              3'h1
`define SEL_IDX2              3'h2
`define SEL_RIGHT_ACC         3'h3
`define SEL_IDX4              3'h4
`define SEL_IDX5              3'h5

`endif

// file: hw/addr_modify_pkg.sv
// Types shared by the address-modify and store-address execution block.
package addr_modify_pkg;

  typedef logic [8:0] opcode_t;
  typedef logic [2:0] index_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_IDX_CLEAR = 3'h1,
    ST_IDX_FILL  = 3'h2,
    ST_IDX_WRITE = 3'h3,
    ST_SA_READ   = 3'h4,
    ST_SA_WRITE  = 3'h5,
    ST_HOLD      = 3'h6
  } exec_state_t;

endpackage

// file: hw/op_timer.sv
// Down counter that stretches an instruction to its documented execution time.
`timescale 1ns/1ps
`default_nettype none
module op_timer #(
  parameter int CNT_W = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load_val,
  output var  logic             idle
);

  if (CNT_W < 1) begin : g_bad_width
    $error("counter width must be at least one bit");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign idle = (cnt_r == '0);

endmodule
`default_nettype wire

// file: hw/address_modify_and_store_address.sv
// Execution of index load from right accumulator, address modification and store-address.
`timescale 1ns/1ps
`default_nettype none
`include "addr_modify_consts.svh"
module address_modify_and_store_address #(
  parameter int AW = 16
) (
  input  wire logic                            ref_clk,
  input  wire logic                            arst_n,
  input  wire logic                            instr_valid,
  input  wire addr_modify_pkg::opcode_t        instr_opcode,
  input  wire addr_modify_pkg::index_sel_t     instr_index_sel,
  input  wire logic [AW-1:0]                   instr_addr,
  input  wire logic                            instr_branch,
  input  wire logic [AW-1:0]                   prog_counter,
  input  wire logic [AW-1:0]                   right_acc,
  input  wire logic [2*AW-1:0]                 mem_rd_data,
  input  wire logic                            mem_rd_valid,
  output var  logic                            busy,
  output var  logic                            done,
  output var  logic [AW-1:0]                   eff_addr,
  output var  logic [AW-1:0]                   right_a,
  output var  logic [3:0][AW-1:0]              index_regs,
  output var  logic                            mem_rd_req,
  output var  logic                            mem_wr_req,
  output var  logic [AW-1:0]                   mem_addr,
  output var  logic [2*AW-1:0]                 mem_wr_data
);
  import addr_modify_pkg::*;

  localparam int TW = `TIMER_W;
  if (AW < 2 || `STORE_ADDR_CYCLES >= (1 << TW) || `INDEX_LOAD_CYCLES >= (1 << TW)) begin : g_bad_cfg
    $error("address width or timer width cannot serve this configuration");
  end

  // Index selectors 1, 2, 4 and 5 map onto the four physical index slots.
  function automatic logic [1:0] slot_of(input logic [2:0] sel);
    case (sel)
      `SEL_IDX1: slot_of = 2'h0;
      `SEL_IDX2: slot_of = 2'h1;
      `SEL_IDX4: slot_of = 2'h2;
      default:   slot_of = 2'h3;
    endcase
  endfunction

  function automatic logic is_idx_sel(input logic [2:0] sel);
    is_idx_sel = (sel == `SEL_IDX1) || (sel == `SEL_IDX2) || (sel == `SEL_IDX4) || (sel == `SEL_IDX5);
  endfunction

  // The right accumulator is only read here, never stepped, so it gives no sequence.
  function automatic logic [AW-1:0] modifier(input logic [2:0]         sel,
                                             input logic [AW-1:0]      racc,
                                             input logic [3:0][AW-1:0] idx);
    if (sel == `SEL_RIGHT_ACC) begin
      modifier = racc;
    end else if (is_idx_sel(sel)) begin
      modifier = idx[slot_of(sel)];
    end else begin
      modifier = '0;
    end
  endfunction

  exec_state_t        state_r;
  exec_state_t        state_nxt;
  opcode_t            op_r;
  opcode_t            op_nxt;
  index_sel_t         sel_r;
  index_sel_t         sel_nxt;
  logic [AW-1:0]      addr_reg_r;
  logic [AW-1:0]      addr_reg_nxt;
  logic [3:0][AW-1:0] idx_r;
  logic [3:0][AW-1:0] idx_nxt;
  logic [AW-1:0]      right_a_r;
  logic [AW-1:0]      right_a_nxt;
  logic [AW-1:0]      eff_addr_r;
  logic [AW-1:0]      eff_addr_nxt;
  logic               busy_r;
  logic               busy_nxt;
  logic               done_r;
  logic               done_nxt;
  logic               rd_req_r;
  logic               rd_req_nxt;
  logic               wr_req_r;
  logic               wr_req_nxt;
  logic [AW-1:0]      mem_addr_r;
  logic [AW-1:0]      mem_addr_nxt;
  logic [2*AW-1:0]    wr_data_r;
  logic [2*AW-1:0]    wr_data_nxt;
  logic               timer_start;
  logic [TW-1:0]      timer_load;
  logic               timer_idle;
  logic [AW-1:0]      ea_now;
  logic               accept;

  assign accept = instr_valid && (state_r == ST_IDLE);
  assign ea_now = instr_addr + modifier(instr_index_sel, right_acc, idx_r);

  op_timer #(
    .CNT_W (TW)
  ) u_timer (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .start    (timer_start),
    .load_val (timer_load),
    .idle     (timer_idle)
  );

  always_comb begin
    state_nxt    = state_r;
    op_nxt       = op_r;
    sel_nxt      = sel_r;
    addr_reg_nxt = addr_reg_r;
    idx_nxt      = idx_r;
    right_a_nxt  = right_a_r;
    eff_addr_nxt = eff_addr_r;
    busy_nxt     = busy_r;
    done_nxt     = 1'b0;
    rd_req_nxt   = 1'b0;
    wr_req_nxt   = 1'b0;
    mem_addr_nxt = mem_addr_r;
    wr_data_nxt  = wr_data_r;
    timer_start  = 1'b0;
    timer_load   = '0;
    case (state_r)
      ST_IDLE: begin
        if (instr_valid) begin
          op_nxt  = instr_opcode;
          sel_nxt = instr_index_sel;
          // The caller presents the already advanced counter, so right A gets the return address.
          if (instr_branch) begin
            right_a_nxt = prog_counter;
          end
          if (instr_opcode == `OPC_INDEX_LOAD_FROM_RIGHT_ACC) begin
            busy_nxt    = 1'b1;
            timer_start = 1'b1;
            timer_load  = TW'(`INDEX_LOAD_CYCLES - 1);
            state_nxt   = is_idx_sel(instr_index_sel) ? ST_IDX_CLEAR : ST_HOLD;
          end else if (instr_opcode == `OPC_STORE_ADDRESS_HALF) begin
            busy_nxt     = 1'b1;
            timer_start  = 1'b1;
            timer_load   = TW'(`STORE_ADDR_CYCLES - 1);
            eff_addr_nxt = ea_now;
            mem_addr_nxt = ea_now;
            rd_req_nxt   = 1'b1;
            state_nxt    = ST_SA_READ;
          end else begin
            eff_addr_nxt = ea_now;
            done_nxt     = 1'b1;
          end
        end
      end
      ST_IDX_CLEAR: begin
        addr_reg_nxt            = '0;
        idx_nxt[slot_of(sel_r)] = '0;
        state_nxt               = ST_IDX_FILL;
      end
      ST_IDX_FILL: begin
        addr_reg_nxt = right_acc;
        state_nxt    = ST_IDX_WRITE;
      end
      ST_IDX_WRITE: begin
        idx_nxt[slot_of(sel_r)] = addr_reg_r;
        state_nxt               = ST_HOLD;
      end
      ST_SA_READ: begin
        if (mem_rd_valid) begin
          wr_data_nxt = {mem_rd_data[2*AW-1:AW], right_a_r};
          wr_req_nxt  = 1'b1;
          state_nxt   = ST_SA_WRITE;
        end
      end
      ST_SA_WRITE: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        // A slow memory lengthens the store, it never shortens the documented time.
        if (timer_idle) begin
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_IDLE;
      op_r       <= '0;
      sel_r      <= '0;
      addr_reg_r <= '0;
      idx_r      <= '0;
      right_a_r  <= '0;
      eff_addr_r <= '0;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      rd_req_r   <= 1'b0;
      wr_req_r   <= 1'b0;
      mem_addr_r <= '0;
      wr_data_r  <= '0;
    end else begin
      state_r    <= state_nxt;
      op_r       <= op_nxt;
      sel_r      <= sel_nxt;
      addr_reg_r <= addr_reg_nxt;
      idx_r      <= idx_nxt;
      right_a_r  <= right_a_nxt;
      eff_addr_r <= eff_addr_nxt;
      busy_r     <= busy_nxt;
      done_r     <= done_nxt;
      rd_req_r   <= rd_req_nxt;
      wr_req_r   <= wr_req_nxt;
      mem_addr_r <= mem_addr_nxt;
      wr_data_r  <= wr_data_nxt;
    end
  end

  assign busy        = busy_r;
  assign done        = done_r;
  assign eff_addr    = eff_addr_r;
  assign right_a     = right_a_r;
  assign index_regs  = idx_r;
  assign mem_rd_req  = rd_req_r;
  assign mem_wr_req  = wr_req_r;
  assign mem_addr    = mem_addr_r;
  assign mem_wr_data = wr_data_r;

  // Cycles since the last accepted instruction; read only by the checks below.
  logic [TW-1:0] chk_cnt_r;
  logic [TW-1:0] chk_cnt_nxt;
  always_comb begin
    chk_cnt_nxt = accept ? '0 : ((chk_cnt_r == '1) ? chk_cnt_r : chk_cnt_r + TW'(1));
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_cnt_r <= '0;
    end else begin
      chk_cnt_r <= chk_cnt_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  idx5_clear_load_a: assert property (
    accept && instr_opcode == `OPC_INDEX_LOAD_FROM_RIGHT_ACC && instr_index_sel == `SEL_IDX5
    |-> ##2 idx_r[3] == '0 ##2 idx_r[3] == $past(right_acc, 2))
    else $error("index register 5 not cleared then loaded from right accumulator");
  idx_load_time_a: assert property (
    done_r && op_r == `OPC_INDEX_LOAD_FROM_RIGHT_ACC |-> chk_cnt_r == TW'(`INDEX_LOAD_CYCLES))
    else $error("index load did not finish in its execution time");
  ea_right_acc_a: assert property (
    accept && instr_index_sel == `SEL_RIGHT_ACC && instr_opcode != `OPC_INDEX_LOAD_FROM_RIGHT_ACC
    |=> eff_addr_r == $past(instr_addr) + $past(right_acc))
    else $error("right accumulator not added to address field");
  branch_no_step_a: assert property (
    accept && instr_branch && instr_opcode != `OPC_INDEX_LOAD_FROM_RIGHT_ACC |=> $stable(idx_r))
    else $error("branch altered modifier registers");
  left_half_kept_a: assert property (
    $rose(wr_req_r) |-> wr_data_r[2*AW-1:AW] == $past(mem_rd_data[2*AW-1:AW]))
    else $error("store-address disturbed the left half-word");
  store_time_a: assert property (
    done_r && op_r == `OPC_STORE_ADDRESS_HALF |-> chk_cnt_r == TW'(`STORE_ADDR_CYCLES))
    else $error("store-address did not finish in its execution time");
  right_half_src_a: assert property (
    wr_req_r |-> wr_data_r[AW-1:0] == right_a_r && $past(state_r) == ST_SA_READ)
    else $error("store-address right half not taken from right A");
  branch_capture_a: assert property (
    accept && instr_branch |=> right_a_r == $past(prog_counter))
    else $error("branch did not copy program counter to right A");
  right_a_hold_a: assert property (
    !(accept && instr_branch) |=> $stable(right_a_r))
    else $error("right A changed without a branch");

  idx5_load_c: cover property (accept && instr_opcode == `OPC_INDEX_LOAD_FROM_RIGHT_ACC
                               && instr_index_sel == `SEL_IDX5 ##[1:700] done_r);
  store_done_c: cover property (done_r && op_r == `OPC_STORE_ADDRESS_HALF);
  branch_then_store_c: cover property (accept && instr_branch ##[1:10]
                                       accept && instr_opcode == `OPC_STORE_ADDRESS_HALF);

endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the address-modify and store-address block.
`timescale 1ns/1ps
`default_nettype none
`include "addr_modify_consts.svh"
module tb;
  import addr_modify_pkg::*;
  localparam int AW = 16;
  logic               ref_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               instr_valid = 1'b0;
  opcode_t            instr_opcode = '0;
  index_sel_t         instr_index_sel = '0;
  logic [AW-1:0]      instr_addr = '0;
  logic               instr_branch = 1'b0;
  logic [AW-1:0]      prog_counter = '0;
  logic [AW-1:0]      right_acc = '0;
  logic [2*AW-1:0]    mem_rd_data = '0;
  logic               mem_rd_valid = 1'b0;
  logic               busy;
  logic               done;
  logic               mem_rd_req;
  logic               mem_wr_req;
  logic [AW-1:0]      eff_addr;
  logic [AW-1:0]      right_a;
  logic [AW-1:0]      mem_addr;
  logic [3:0][AW-1:0] index_regs;
  logic [2*AW-1:0]    mem_wr_data;
  int                 fail_count = 0;
  int                 n_compared = 0;
  logic [3:0][AW-1:0] m_idx = '0;
  logic [AW-1:0]      m_ra = '0;
  logic [AW-1:0]      m_eff = '0;
  logic [AW-1:0]      rd_addr = '0;
  logic [AW-1:0]      wr_addr = '0;
  logic [2*AW-1:0]    wr_data = '0;
  logic [AW-1:0]      left_sent = '0;
  int                 rd_wait = 0;
  int                 wr_count = 0;

  address_modify_and_store_address #(.AW(AW)) u_address_modify_and_store_address (
    .ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_index_sel(instr_index_sel), .instr_addr(instr_addr), .instr_branch(instr_branch),
    .prog_counter(prog_counter), .right_acc(right_acc), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid), .busy(busy), .done(done), .eff_addr(eff_addr), .right_a(right_a),
    .index_regs(index_regs), .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data));

  always #5 ref_clk = ~ref_clk;

  // Memory stand-in: answers reads after a random delay; between answers the data lines toggle so stale data never matches.
  always @(negedge ref_clk) begin
    if (rd_wait == 1) begin
      mem_rd_valid <= 1'b1;
      mem_rd_data <= {left_sent, AW'($urandom)};
    end else begin
      mem_rd_valid <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
    end
    if (rd_wait > 0) rd_wait <= rd_wait - 1;
    if (mem_rd_req === 1'b1) begin
      rd_addr <= mem_addr;
      rd_wait <= 2 + $urandom % 8;
    end
    if (mem_wr_req === 1'b1) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wr_data;
      wr_count <= wr_count + 1;
    end
  end

  function automatic int slot(input int s);
    case (s)
      1: slot = 0;
      2: slot = 1;
      4: slot = 2;
      5: slot = 3;
      default: slot = -1;
    endcase
  endfunction

  function automatic logic [AW-1:0] modv(input int s, input logic [AW-1:0] racc);
    if (s == 3) modv = racc;
    else if (slot(s) >= 0) modv = m_idx[slot(s)];
    else modv = '0;
  endfunction

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Issues one instruction and counts edges from the taking edge to the done pulse.
  task automatic run(input opcode_t op, input int s, input logic [AW-1:0] a, input logic br,
                     input logic [AW-1:0] pc, input logic [AW-1:0] racc, output int n);
    logic d0;
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_opcode = op;
    instr_index_sel = index_sel_t'(s);
    instr_addr = a;
    instr_branch = br;
    prog_counter = pc;
    right_acc = racc;
    @(posedge ref_clk);
    #1;
    d0 = done;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    n = 0;
    while (d0 !== 1'b1 && done !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 3000) begin
        check(1'b0, "done never came");
        report_and_stop();
      end
    end
  endtask

  initial begin
    int n;
    int w;
    logic [AW-1:0] a;
    logic [AW-1:0] r;
    logic [AW-1:0] p;
    void'($urandom(32'h6146));
    p = '0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    check(busy === 1'b0 && right_a === '0 && index_regs === '0, "reset values");
    for (int s = 0; s < 8; s++) begin
      r = AW'($urandom);
      if (slot(s) >= 0) m_idx[slot(s)] = r;
      run(`OPC_INDEX_LOAD_FROM_RIGHT_ACC, s, AW'($urandom), 1'b0, p, r, n);
      check(n == `INDEX_LOAD_CYCLES && busy === 1'b0, "index load time");
      check(index_regs === m_idx, "index load result");
      check(eff_addr === m_eff, "index load touched address");
    end
    r = AW'($urandom);
    m_idx[3] = r;
    fork
      run(`OPC_INDEX_LOAD_FROM_RIGHT_ACC, 5, '0, 1'b0, p, r, n);
      begin
        @(negedge ref_clk);
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        check(index_regs[3] === '0 && busy === 1'b1, "index 5 not cleared first");
      end
    join
    check(index_regs === m_idx, "index 5 reload");
    $display("test index_load finished");
    for (int i = 0; i < 16; i++) begin
      a = AW'($urandom);
      r = AW'($urandom);
      p = AW'($urandom);
      m_eff = a + modv(i % 8, r);
      if (i >= 8) m_ra = p;
      run(9'h000, i % 8, a, i >= 8, p, r, n);
      check(eff_addr === m_eff, "modified address");
      check(right_a === m_ra, "right A after branch");
      check(index_regs === m_idx, "index register stepped");
    end
    $display("test modify_branch finished");
    for (int k = 0; k < 2; k++) begin
      p = AW'($urandom);
      m_ra = p;
      run(9'h000, 0, '0, 1'b1, p, '0, n);
      a = AW'($urandom);
      r = AW'($urandom);
      left_sent = AW'($urandom);
      m_eff = a + modv(k ? 1 : 3, r);
      w = wr_count;
      run(`OPC_STORE_ADDRESS_HALF, k ? 1 : 3, a, 1'b0, p + 1'b1, r, n);
      check(n == `STORE_ADDR_CYCLES, "store time");
      check(wr_count == w + 1 && wr_addr === m_eff && rd_addr === m_eff, "store address");
      check(wr_data === {left_sent, m_ra}, "store word");
      check(right_a === m_ra && eff_addr === m_eff, "store side effects");
    end
    $display("test store_address finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
